// ### common/fsc_map.svh
// Register offsets, field positions, reset values and timing counts of the fan controller
`ifndef FSC_MAP_SVH
`define FSC_MAP_SVH

`define FSC_OFS_SEL1        8'h05
`define FSC_OFS_SEL2        8'h06
`define FSC_OFS_CEIL1       8'h34
`define FSC_OFS_CEIL2       8'h35
`define FSC_OFS_ACOU        8'h36
`define FSC_OFS_DRV1        8'h40
`define FSC_OFS_DRV2        8'h41
`define FSC_OFS_BTEST       8'h42

`define FSC_RST_SEL         8'h0C
`define FSC_RST_CEIL        8'h20
`define FSC_RST_ACOU        8'h3F
`define FSC_RST_BTEST       8'h00
`define FSC_RST_DRV         8'h00

`define FSC_SEL_MAN_BIT     4
`define FSC_SEL_MIN_BIT     5
`define FSC_SEL_STRT_BIT    6
`define FSC_SEL_MAX_BIT     7
`define FSC_ACOU_STEP_W     3
`define FSC_ACOU_EN_BIT     6
`define FSC_BTEST_EN_BIT    0

`define FSC_FULL_SCALE      8'hFF
`define FSC_ZERO_DRIVE      8'h00

`define FSC_CLK_MHZ         200
`define FSC_MS_CYCLES       (`FSC_CLK_MHZ * 1000)
`define FSC_LOOP_MS         250
`define FSC_RETRY_WAIT_MIN  1
`define FSC_RETRY_WAIT_MS   (`FSC_RETRY_WAIT_MIN * 60000)
`define FSC_MAX_RETRIES     5
`define FSC_SPIN_PULSES     2

`define FSC_TO1_MS          100
`define FSC_TO2_MS          250
`define FSC_TO3_MS          400
`define FSC_TO4_MS          667
`define FSC_TO5_S           1
`define FSC_TO6_S           2
`define FSC_TO7_S           4

`endif

// ### common/fsc_pkg.sv
// Types shared by the fan speed controller
package fsc_pkg;
    typedef enum logic [1:0] {
        FSC_ST_IDLE = 2'b00,
        FSC_ST_SPIN = 2'b01,
        FSC_ST_RUN  = 2'b11,
        FSC_ST_WAIT = 2'b10
    } fsc_state_t;
endpackage : fsc_pkg

// ### core/fsc_fan_ctrl.sv
// Two-fan automatic speed control with start-up, smoothing, overrides and board test
`timescale 1ns/100ps
`default_nettype none
`include "fsc_map.svh"

// Operation
// - Start-up timeout code picks none, 100, 250, 400, 667 ms, 1, 2, 4 s.
// - Low four select bits pick channels; highest demanded speed wins.
// - Manual bit stops automatic loop; drive register becomes software written.
// - Bits 5, 6, 7 force min, start, max; higher bit overrides lower.
// - Automatic loop never raises drive while fan exceeds its speed ceiling.
// - With select bits 7:4 clear, thermal breach forces full scale until temperature drops hysteresis below limit.
// - Above start temperature drive rises linearly from minimum to full over span.
// - Smoothing register holds 3-bit step codes, fan 1 bits 2:0, fan 2 5:3.
// - With smoothing, drive steps toward target once every 250 ms.
// - Smoothing enables are bit 6 for fan 1, bit 7 for fan 2.
// - On first exceeding start temperature, output start level; fan 1 power on.
// - Two tach pulses confirm start; drive then drops to minimum level.
// - Below start temperature run at minimum, or switch off below hysteresis.
// - Fan one power output is low whenever fan 1 drive is zero.
// - Automatic loop recomputes drive every 250 ms.
// - Failed start raises start level by step, retries five times or until a try at full scale fails, then stuck.
// - After failed sequence drive zero, wait one minute, repeat sequence.
// - Board test bit 0 enables the XOR chain over the test pins.
// - No tach pulses within timeout flags a spin-up fault.
// - With pulse wait disabled, drive full for the whole start-up timeout.
module fsc_fan_ctrl
    import fsc_pkg::*;
#(
    parameter int MS_CYCLES = `FSC_MS_CYCLES,
    parameter int XOR_PINS  = 8
) (
    input  wire logic                i_core_clk,
    input  wire logic                i_rst_n,
    input  wire logic                i_reg_wr,
    input  wire logic [7:0]          i_reg_addr,
    input  wire logic [7:0]          i_reg_wdata,
    output logic      [7:0]          o_reg_rdata,
    input  wire logic [31:0]         i_temp_ch,
    input  wire logic [31:0]         i_start_temp_ch,
    input  wire logic [15:0]         i_span_log2_ch,
    input  wire logic [7:0]          i_therm_limit,
    input  wire logic [7:0]          i_therm_hyst,
    input  wire logic [7:0]          i_off_hyst,
    input  wire logic [1:0]          i_keep_min,
    input  wire logic [15:0]         i_start_level,
    input  wire logic [15:0]         i_min_level,
    input  wire logic [15:0]         i_retry_step,
    input  wire logic [5:0]          i_timeout_code,
    input  wire logic                i_spinup_pulse_wait_disable,
    input  wire logic [31:0]         i_tach_period,
    input  wire logic [1:0]          i_tach,
    input  wire logic [XOR_PINS-1:0] i_xor_pins,
    output logic      [7:0]          o_fan_one_drive,
    output logic      [7:0]          o_fan_two_drive,
    output logic                     o_fan_one_power_output,
    output logic                     o_fan_stuck_output,
    output logic      [1:0]          o_spinup_fault,
    output logic                     o_board_test_mode,
    output logic                     o_xor_out
);
    localparam int SYNC_W = XOR_PINS + 2;
    localparam int WAIT_MS = `FSC_RETRY_WAIT_MS;

    if (MS_CYCLES < 1 || XOR_PINS < 1) begin : g_bad_param
        $error("fsc_fan_ctrl: parameter out of range");
    end

    logic [7:0]        sel_r [2];
    logic [7:0]        ceil_r [2];
    logic [7:0]        acou_r;
    logic [7:0]        btest_r;
    logic [7:0]        drive_r [2];
    logic [7:0]        out_r [2];
    logic [SYNC_W-1:0] sync1_r;
    logic [SYNC_W-1:0] sync2_r;
    logic [1:0]        tach_d_r;
    logic [31:0]       ms_cnt_r;
    logic              ms_tick;
    logic [7:0]        loop_ms_r;
    logic              loop_tick;
    logic [1:0]        stuck_r;
    logic [1:0]        fault_r;

    // Registers written by software
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sel_r[0]  <= `FSC_RST_SEL;
            sel_r[1]  <= `FSC_RST_SEL;
            ceil_r[0] <= `FSC_RST_CEIL;
            ceil_r[1] <= `FSC_RST_CEIL;
            acou_r    <= `FSC_RST_ACOU;
            btest_r   <= `FSC_RST_BTEST;
        end else if (i_reg_wr) begin
            case (i_reg_addr)
                `FSC_OFS_SEL1:  sel_r[0]  <= i_reg_wdata;
                `FSC_OFS_SEL2:  sel_r[1]  <= i_reg_wdata;
                `FSC_OFS_CEIL1: ceil_r[0] <= i_reg_wdata;
                `FSC_OFS_CEIL2: ceil_r[1] <= i_reg_wdata;
                `FSC_OFS_ACOU:  acou_r    <= i_reg_wdata;
                `FSC_OFS_BTEST: btest_r   <= i_reg_wdata;
                default: ;
            endcase
        end
    end

    // Read data, one cycle after the address
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_reg_rdata <= 8'h00;
        end else begin
            case (i_reg_addr)
                `FSC_OFS_SEL1:  o_reg_rdata <= sel_r[0];
                `FSC_OFS_SEL2:  o_reg_rdata <= sel_r[1];
                `FSC_OFS_CEIL1: o_reg_rdata <= ceil_r[0];
                `FSC_OFS_CEIL2: o_reg_rdata <= ceil_r[1];
                `FSC_OFS_ACOU:  o_reg_rdata <= acou_r;
                `FSC_OFS_DRV1:  o_reg_rdata <= out_r[0];
                `FSC_OFS_DRV2:  o_reg_rdata <= out_r[1];
                `FSC_OFS_BTEST: o_reg_rdata <= btest_r;
                default:        o_reg_rdata <= 8'h00;
            endcase
        end
    end

    // Pin synchronisers; reset to idle high so no false tach edge follows reset
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync1_r  <= '1;
            sync2_r  <= '1;
            tach_d_r <= 2'b11;
        end else begin
            sync1_r  <= {i_xor_pins, i_tach};
            sync2_r  <= sync1_r;
            tach_d_r <= sync2_r[1:0];
        end
    end

    // Board test chain
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_board_test_mode <= 1'b0;
            o_xor_out         <= 1'b0;
        end else begin
            o_board_test_mode <= btest_r[`FSC_BTEST_EN_BIT];
            o_xor_out <= btest_r[`FSC_BTEST_EN_BIT] & (^sync2_r[SYNC_W-1:2]);
        end
    end

    // Millisecond and loop ticks
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ms_cnt_r  <= 32'h0000_0000;
            loop_ms_r <= 8'h00;
        end else begin
            ms_cnt_r <= ms_tick ? 32'h0000_0000 : ms_cnt_r + 32'h0000_0001;
            if (ms_tick) begin
                loop_ms_r <= loop_tick ? 8'h00 : loop_ms_r + 8'h01;
            end
        end
    end
    assign ms_tick   = (ms_cnt_r == 32'(MS_CYCLES - 1));
    assign loop_tick = ms_tick && (loop_ms_r == 8'(`FSC_LOOP_MS - 1));

    // Linear level above the start temperature
    function automatic logic [7:0] slope_level(input logic [7:0] temp,
                                               input logic [7:0] t_on,
                                               input logic [3:0] span_log2,
                                               input logic [7:0] min_lvl);
        logic [15:0] prod;
        logic [15:0] sum;
        prod = (16'(`FSC_FULL_SCALE - min_lvl) * 16'(temp - t_on)) >> span_log2;
        sum  = prod + 16'(min_lvl);
        return (sum > 16'(`FSC_FULL_SCALE)) ? `FSC_FULL_SCALE : sum[7:0];
    endfunction

    function automatic logic [15:0] timeout_ms(input logic [2:0] code);
        case (code)
            3'h1:    return 16'(`FSC_TO1_MS);
            3'h2:    return 16'(`FSC_TO2_MS);
            3'h3:    return 16'(`FSC_TO3_MS);
            3'h4:    return 16'(`FSC_TO4_MS);
            3'h5:    return 16'(`FSC_TO5_S * 1000);
            3'h6:    return 16'(`FSC_TO6_S * 1000);
            3'h7:    return 16'(`FSC_TO7_S * 1000);
            default: return 16'h0000;
        endcase
    endfunction

    function automatic logic [7:0] step_size(input logic [2:0] code);
        case (code)
            3'h0:    return 8'h01;
            3'h1:    return 8'h02;
            3'h2:    return 8'h03;
            3'h3:    return 8'h04;
            3'h4:    return 8'h08;
            3'h5:    return 8'h10;
            3'h6:    return 8'h20;
            default: return 8'h30;
        endcase
    endfunction

    for (genvar f = 0; f < 2; f++) begin : g_fan
        fsc_state_t state_r;
        logic [15:0] cnt_r;
        logic [1:0]  pulses_r;
        logic [2:0]  tries_r;
        logic [7:0]  start_lvl_r;
        logic        emerg_r;
        logic [7:0]  lvl;
        logic        demand;
        logic        hot;
        logic        cool;
        logic        below_off;
        logic [7:0]  auto_tgt;
        logic [7:0]  stp;
        logic [7:0]  ramped;
        logic [15:0] to_ms;
        logic        pulse;
        logic        capped;
        logic [7:0]  t;
        logic [7:0]  t_on;
        logic [7:0]  min_lvl;
        logic [7:0]  raised;

        assign min_lvl = i_min_level[8*f +: 8];
        assign pulse   = sync2_r[f] & ~tach_d_r[f];
        assign to_ms   = timeout_ms(i_timeout_code[3*f +: 3]);
        assign stp     = step_size(acou_r[`FSC_ACOU_STEP_W*f +: `FSC_ACOU_STEP_W]);
        assign capped  = (ceil_r[f] != 8'h00) &&
                         (i_tach_period[16*f+8 +: 8] < ceil_r[f]);
        assign raised  = ({1'b0, start_lvl_r} + {1'b0, i_retry_step[8*f +: 8]} > 9'h0FF)
                         ? `FSC_FULL_SCALE : start_lvl_r + i_retry_step[8*f +: 8];

        always_comb begin
            lvl       = 8'h00;
            demand    = 1'b0;
            hot       = 1'b0;
            cool      = 1'b1;
            below_off = 1'b1;
            t         = 8'h00;
            t_on      = 8'h00;
            for (int c = 0; c < 4; c++) begin
                t    = i_temp_ch[8*c +: 8];
                t_on = i_start_temp_ch[8*c +: 8];
                if (sel_r[f][c]) begin
                    if (t > t_on) begin
                        demand = 1'b1;
                        if (slope_level(t, t_on, i_span_log2_ch[4*c +: 4], min_lvl) > lvl)
                            lvl = slope_level(t, t_on, i_span_log2_ch[4*c +: 4], min_lvl);
                    end
                    if (t > i_therm_limit) hot = 1'b1;
                    if ({1'b0, t} + {1'b0, i_therm_hyst} >= {1'b0, i_therm_limit})
                        cool = 1'b0;
                    if ({1'b0, t} + {1'b0, i_off_hyst} >= {1'b0, t_on})
                        below_off = 1'b0;
                end
            end
            auto_tgt = demand ? lvl : min_lvl;
            if (capped && auto_tgt > drive_r[f]) auto_tgt = drive_r[f];
            if (!acou_r[`FSC_ACOU_EN_BIT + f]) begin
                ramped = auto_tgt;
            end else if (auto_tgt > drive_r[f]) begin
                ramped = (auto_tgt - drive_r[f] > stp) ? drive_r[f] + stp : auto_tgt;
            end else begin
                ramped = (drive_r[f] - auto_tgt > stp) ? drive_r[f] - stp : auto_tgt;
            end
        end

        // Thermal override flag with hysteresis
        always_ff @(posedge i_core_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                emerg_r <= 1'b0;
            end else if (sel_r[f][7:4] != 4'h0) begin
                emerg_r <= 1'b0;
            end else if (hot) begin
                emerg_r <= 1'b1;
            end else if (cool) begin
                emerg_r <= 1'b0;
            end
        end

        // Drive output, full scale bypasses ramping
        always_ff @(posedge i_core_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                out_r[f] <= `FSC_ZERO_DRIVE;
            end else begin
                out_r[f] <= emerg_r ? `FSC_FULL_SCALE : drive_r[f];
            end
        end

        // Start-up sequence and loop
        always_ff @(posedge i_core_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                state_r     <= FSC_ST_IDLE;
                drive_r[f]  <= `FSC_RST_DRV;
                cnt_r       <= 16'h0000;
                pulses_r    <= 2'b00;
                tries_r     <= 3'h0;
                start_lvl_r <= `FSC_ZERO_DRIVE;
                stuck_r[f]  <= 1'b0;
                fault_r[f]  <= 1'b0;
            end else if (sel_r[f][`FSC_SEL_MAX_BIT]) begin
                state_r    <= FSC_ST_IDLE;
                drive_r[f] <= `FSC_FULL_SCALE;
            end else if (sel_r[f][`FSC_SEL_STRT_BIT]) begin
                state_r    <= FSC_ST_IDLE;
                drive_r[f] <= i_start_level[8*f +: 8];
            end else if (sel_r[f][`FSC_SEL_MIN_BIT]) begin
                state_r    <= FSC_ST_IDLE;
                drive_r[f] <= min_lvl;
            end else if (sel_r[f][`FSC_SEL_MAN_BIT]) begin
                state_r <= FSC_ST_IDLE;
                if (i_reg_wr && i_reg_addr == 8'(`FSC_OFS_DRV1 + f))
                    drive_r[f] <= i_reg_wdata;
            end else begin
                if (ms_tick) cnt_r <= cnt_r + 16'h0001;
                case (state_r)
                    FSC_ST_IDLE: begin
                        drive_r[f] <= `FSC_ZERO_DRIVE;
                        if (demand) begin
                            state_r     <= FSC_ST_SPIN;
                            start_lvl_r <= i_start_level[8*f +: 8];
                            drive_r[f]  <= i_start_level[8*f +: 8];
                            cnt_r       <= 16'h0000;
                            pulses_r    <= 2'b00;
                            tries_r     <= 3'h0;
                        end
                    end
                    FSC_ST_SPIN: begin
                        drive_r[f] <= i_spinup_pulse_wait_disable ? `FSC_FULL_SCALE
                                                                  : start_lvl_r;
                        if (pulse) pulses_r <= pulses_r + 2'b01;
                        if (!i_spinup_pulse_wait_disable && pulse &&
                            pulses_r == 2'(`FSC_SPIN_PULSES - 1)) begin
                            state_r    <= FSC_ST_RUN;
                            drive_r[f] <= min_lvl;
                            stuck_r[f] <= 1'b0;
                            fault_r[f] <= 1'b0;
                        end else if (to_ms != 16'h0000 && cnt_r >= to_ms) begin
                            cnt_r    <= 16'h0000;
                            pulses_r <= 2'b00;
                            if (i_spinup_pulse_wait_disable) begin
                                state_r    <= FSC_ST_RUN;
                                drive_r[f] <= min_lvl;
                            end else begin
                                fault_r[f] <= 1'b1;
                                if (tries_r < 3'(`FSC_MAX_RETRIES) &&
                                    start_lvl_r != `FSC_FULL_SCALE) begin
                                    tries_r     <= tries_r + 3'h1;
                                    start_lvl_r <= raised;
                                end else begin
                                    stuck_r[f] <= 1'b1;
                                    drive_r[f] <= `FSC_ZERO_DRIVE;
                                    state_r    <= FSC_ST_WAIT;
                                end
                            end
                        end
                    end
                    FSC_ST_WAIT: begin
                        drive_r[f] <= `FSC_ZERO_DRIVE;
                        if (cnt_r >= 16'(WAIT_MS)) begin
                            state_r     <= FSC_ST_SPIN;
                            start_lvl_r <= i_start_level[8*f +: 8];
                            cnt_r       <= 16'h0000;
                            pulses_r    <= 2'b00;
                            tries_r     <= 3'h0;
                        end
                    end
                    FSC_ST_RUN: begin
                        if (loop_tick) begin
                            if (!demand && !i_keep_min[f] && below_off) begin
                                state_r    <= FSC_ST_IDLE;
                                drive_r[f] <= `FSC_ZERO_DRIVE;
                            end else begin
                                drive_r[f] <= ramped;
                            end
                        end
                    end
                    default: state_r <= FSC_ST_IDLE;
                endcase
            end
        end
    end

    // Pin outputs
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_fan_one_drive        <= `FSC_ZERO_DRIVE;
            o_fan_two_drive        <= `FSC_ZERO_DRIVE;
            o_fan_one_power_output <= 1'b0;
            o_fan_stuck_output     <= 1'b0;
            o_spinup_fault         <= 2'b00;
        end else begin
            o_fan_one_drive        <= out_r[0];
            o_fan_two_drive        <= out_r[1];
            o_fan_one_power_output <= (out_r[0] != `FSC_ZERO_DRIVE);
            o_fan_stuck_output     <= |stuck_r;
            o_spinup_fault         <= fault_r;
        end
    end
endmodule : fsc_fan_ctrl
`default_nettype wire

// ### sim/fsc_fan_ctrl_monitor.sv
// Port checker of the fan controller
`timescale 1ns/100ps
`default_nettype none
module fsc_fan_ctrl_monitor #(
    parameter int XOR_PINS = 8
) (
    input wire logic                i_core_clk,
    input wire logic                i_rst_n,
    input wire logic                i_reg_wr,
    input wire logic [7:0]          i_reg_addr,
    input wire logic [7:0]          i_reg_wdata,
    input wire logic [7:0]          o_reg_rdata,
    input wire logic [XOR_PINS-1:0] i_xor_pins,
    input wire logic [7:0]          o_fan_one_drive,
    input wire logic                o_fan_one_power_output,
    input wire logic                o_fan_stuck_output,
    input wire logic [1:0]          o_spinup_fault,
    input wire logic                o_board_test_mode,
    input wire logic                o_xor_out
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    AST_PWR_OFF: assert property (
        (o_fan_one_drive == 8'h00)[*3] |-> !$past(o_fan_one_power_output))
        else $error("fan one power high at zero drive");
    AST_PWR_ON: assert property (
        (o_fan_one_drive != 8'h00)[*3] |-> $past(o_fan_one_power_output))
        else $error("fan one power low while driven");
    AST_XOR_IDLE: assert property (
        (!o_board_test_mode)[*3] |-> !$past(o_xor_out))
        else $error("xor output active outside test mode");
    AST_XOR_VAL: assert property (
        (o_board_test_mode && $stable(i_xor_pins))[*5] |-> o_xor_out == ^i_xor_pins)
        else $error("xor output wrong");
    AST_RD_ACOU: assert property (
        i_reg_wr && i_reg_addr == 8'h36 ##1 !i_reg_wr && i_reg_addr == 8'h36
        |=> o_reg_rdata == $past(i_reg_wdata, 2))
        else $error("smoothing readback wrong");
    AST_BTEST: assert property (
        i_reg_wr && i_reg_addr == 8'h42 |-> ##2 o_board_test_mode == $past(i_reg_wdata[0], 2))
        else $error("test mode does not follow enable bit");
    AST_FORCE_MAX: assert property (
        i_reg_wr && i_reg_addr == 8'h05 && i_reg_wdata[7] |-> ##[1:600] o_fan_one_drive == 8'hFF)
        else $error("forced full speed not reached");
    AST_STUCK: assert property (
        $rose(o_fan_stuck_output) |-> o_spinup_fault != 2'b00)
        else $error("stuck without start fault");
endmodule : fsc_fan_ctrl_monitor
bind fsc_fan_ctrl fsc_fan_ctrl_monitor #(.XOR_PINS(XOR_PINS)) i_mon (.i_core_clk, .i_rst_n,
    .i_reg_wr, .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .i_xor_pins, .o_fan_one_drive,
    .o_fan_one_power_output, .o_fan_stuck_output, .o_spinup_fault, .o_board_test_mode,
    .o_xor_out);
`default_nettype wire

// ### sim/fsc_fan_model.sv
// Two fans giving tach pulses while driven
`timescale 1ns/100ps
`default_nettype none
module fsc_fan_model #(
    parameter int HALF = 7
) (
    input  wire logic       i_core_clk,
    input  wire logic [7:0] i_drive_one,
    input  wire logic [7:0] i_drive_two,
    input  wire logic [1:0] i_stall,
    output logic      [1:0] o_tach = 2'b11
);
    int cnt_r [2];
    always_ff @(posedge i_core_clk) begin
        for (int f = 0; f < 2; f++) begin
            // Idle or stalled fan leaves tach at pull-up level
            if ((f == 0 ? i_drive_one : i_drive_two) == 8'h00 || i_stall[f]) begin
                o_tach[f] <= 1'b1;
                cnt_r[f]  <= 0;
            end else if (cnt_r[f] == HALF) begin
                o_tach[f] <= ~o_tach[f];
                cnt_r[f]  <= 0;
            end else begin
                cnt_r[f] <= cnt_r[f] + 1;
            end
        end
    end
endmodule : fsc_fan_model
`default_nettype wire

// ### sim/fsc_fan_ctrl_tb.sv
// Self-checking bench of the fan controller
`timescale 1ns/100ps
`default_nettype none
module fsc_fan_ctrl_tb;
    logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, pwr, stuck, btm, xo;
    logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata, drv1, drv2, pins = 8'h00;
    logic [31:0] temp = 32'h28282828, t_on = 32'h32323232, period = 32'hFFFFFFFF;
    logic [15:0] st_lvl = 16'h8080, mn_lvl = 16'h6060, rstep = 16'h1010;
    logic [7:0]  tlim = 8'h64;
    logic [5:0]  to_code = 6'h08;
    logic [1:0]  keep = 2'b11;
    logic        spin_dis = 1'b0;
    logic [1:0]  tach, fault, stall = 2'b00;
    logic [7:0]  ra [7] = '{8'h05, 8'h06, 8'h34, 8'h35, 8'h36, 8'h42, 8'h07};
    logic [7:0]  rv [7] = '{8'h0C, 8'h0C, 8'h20, 8'h20, 8'h3F, 8'h00, 8'h00};
    logic [7:0]  fs [3] = '{8'hE0, 8'h60, 8'h20};
    logic [7:0]  fv [3] = '{8'hFF, 8'h80, 8'h60};
    int          err_total = 0, checks_done = 0, cyc = 0;
    fsc_fan_ctrl #(.MS_CYCLES(2), .XOR_PINS(8)) i_dut (.i_core_clk(clk), .i_rst_n(rst_n),
        .i_reg_wr(wr), .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
        .i_temp_ch(temp), .i_start_temp_ch(t_on), .i_span_log2_ch(16'h4444),
        .i_therm_limit(tlim), .i_therm_hyst(8'h0A), .i_off_hyst(8'h05), .i_keep_min(keep),
        .i_start_level(st_lvl), .i_min_level(mn_lvl), .i_retry_step(rstep),
        .i_timeout_code(to_code), .i_spinup_pulse_wait_disable(spin_dis),
        .i_tach_period(period), .i_tach(tach), .i_xor_pins(pins),
        .o_fan_one_drive(drv1), .o_fan_two_drive(drv2), .o_fan_one_power_output(pwr),
        .o_fan_stuck_output(stuck), .o_spinup_fault(fault), .o_board_test_mode(btm),
        .o_xor_out(xo));
    fsc_fan_model i_fans (.i_core_clk(clk), .i_drive_one(drv1), .i_drive_two(drv2),
        .i_stall(stall), .o_tach(tach));
    initial forever #2.5 clk = ~clk;
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) begin wr <= 1'b1; addr <= a; wdata <= d; end
        @(posedge clk) wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk) addr <= a;
        repeat (2) @(posedge clk);
        #1 check(rdata, exp, "rdata");
    endtask : rd_chk
    task automatic tally_and_finish();
        if (err_total == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : tally_and_finish
    initial forever begin
        @(posedge clk);
        cyc++;
        if (cyc == 20000) begin err_total++; tally_and_finish(); end
    end
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 7; i++) rd_chk(ra[i], rv[i]);
        wr_reg(8'h36, 8'hC7);
        rd_chk(8'h36, 8'hC7);
        wr_reg(8'h36, 8'h07);
        for (int i = 0; i < 3; i++) begin
            wr_reg(8'h05, fs[i]);
            repeat (1100) @(posedge clk);
            check(drv1, fv[i], "forced drv1");
        end
        wr_reg(8'h34, 8'h00);
        wr_reg(8'h35, 8'h00);
        wr_reg(8'h05, 8'h10);
        wr_reg(8'h40, 8'h5A);
        repeat (5) @(posedge clk);
        check(drv1, 8'h5A, "manual drv1");
        wr_reg(8'h40, 8'h00);
        repeat (5) @(posedge clk);
        check(pwr, 1'b0, "power");
        wr_reg(8'h05, 8'h01);
        temp[7:0] <= 8'h3C;
        repeat (1100) @(posedge clk);
        check(pwr, 1'b1, "power");
        check(drv1, 8'hC3, "slope drv1");
        check(fault, 2'b00, "fault");
        temp[7:0] <= 8'h6E;
        repeat (1100) @(posedge clk);
        check(drv1, 8'hFF, "hot drv1");
        temp[7:0] <= 8'h3C;
        repeat (1100) @(posedge clk);
        check(drv1, 8'hC3, "cooled drv1");
        stall <= 2'b10;
        wr_reg(8'h06, 8'h02);
        temp[15:8] <= 8'h3C;
        repeat (800) @(posedge clk);
        check(fault[1], 1'b1, "fault");
        repeat (2500) @(posedge clk);
        check(stuck, 1'b1, "stuck");
        check(drv2, 8'h00, "drv2");
        wr_reg(8'h02, 8'h02);
        wr_reg(8'h13, 8'h02);
        pins <= 8'h05;
        wr_reg(8'h42, 8'h01);
        repeat (10) @(posedge clk);
        check(xo, 1'b0, "xor");
        pins <= 8'h07;
        repeat (10) @(posedge clk);
        check({btm, xo}, 2'b11, "xor");
        keep <= 2'b00;
        temp[7:0] <= 8'h28;
        repeat (1100) @(posedge clk);
        check(drv1, 8'h00, "off drv1");
        spin_dis <= 1'b1;
        temp[7:0] <= 8'h3C;
        repeat (100) @(posedge clk);
        check(drv1, 8'hFF, "spin drv1");
        tally_and_finish();
    end
endmodule : fsc_fan_ctrl_tb
`default_nettype wire
